/* File: rtl/bbx_cfg.svh */
// Constants of the byte and bit execute block: widths, file addresses,
// bus map, field positions and reset values.
// Assumes it is included by bare name before the package and the module.
`ifndef BBX_CFG_SVH
`define BBX_CFG_SVH

// Operand and file-space widths
`define BBX_DATA_W      8
`define BBX_FILE_W      7

// Special file addresses inside the 128-byte file space
`define BBX_TMR_ADDR    7'h01
`define BBX_PORT_ADDR   7'h05

// Register bus map, byte addresses
`define BBX_REG_WORK    8'h00
`define BBX_REG_FLAGS   8'h01
`define BBX_REG_CTRL    8'h02
`define BBX_REG_STATE   8'h03
`define BBX_FILE_WIN    7

// Field positions in the flag, control and state registers
`define BBX_FLAG_C      0
`define BBX_FLAG_DIG    1
`define BBX_FLAG_Z      2
`define BBX_CTRL_PSA    0
`define BBX_STATE_NOP   0

// Reset values
`define BBX_WORK_RST    8'h00
`define BBX_FILE_RST    8'h00
`define BBX_RDATA_RST   8'h00

`endif

/* File: rtl/bbx_exec.sv */
// Execute stage for literal and file add/AND, bit set/clear and
// bit-test-skip, with the file space, working register and flags.
// Assumes a decoder presents one instruction per cycle on ins_* and a
// fetch unit honours skip_next by discarding the following instruction.
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "bbx_cfg.svh"

// Contract
// - Read-modify-write of the I/O port reads pin levels, not the latch.
// - Writing the timer counter by instruction clears its prescaler when assigned; bus writes do not.
// - Skipping instructions take two cycles; the second is a NOP.
// - Literal add puts work plus literal in work; sets all three flags.
// - File add sums work and file register 0..127; sets all flags.
// - Destination zero writes work; destination one writes the file.
// - Literal AND puts work AND literal in work; only Z changes.
// - File AND goes to the chosen destination; only Z changes.
// - Bit clear zeroes one bit of a file register; flags untouched.
// - Bit set raises one bit of a file register; flags untouched.
// - Test-skip runs next instruction if bit set, else a NOP cycle.
module bbx_exec #(
   parameter int FILE_W = `BBX_FILE_W
) (
   input  wire logic              clock,
   input  wire logic              nrst,
   input  wire logic              ce,
   input  wire logic              ins_valid,
   output logic                   ins_ready,
   input  wire bbx_pkg::bbx_op_t  ins_op,
   input  wire logic [FILE_W-1:0] ins_file,
   input  wire logic [2:0]        ins_bit,
   input  wire logic              ins_dest,
   input  wire logic [7:0]        ins_literal,
   output logic                   skip_next,
   output logic                   nop_cycle,
   output logic                   prescaler_clear,
   input  wire logic [7:0]        port_pins,
   output logic [7:0]             port_latch,
   output logic [7:0]             work,
   output logic                   carry,
   output logic                   digit_carry_flag,
   output logic                   zero,
   input  wire logic [7:0]        bus_addr,
   input  wire logic [7:0]        bus_wdata,
   input  wire logic              bus_wr,
   input  wire logic              bus_rd,
   output logic [7:0]             bus_rdata
);
   import bbx_pkg::*;

   localparam int DEPTH = 2 ** FILE_W;

   bbx_state_t        state;
   logic [7:0]        file_mem [DEPTH];
   logic              prescaler_assigned;
   logic              exec_fire;
   logic [7:0]        opnd;
   logic [7:0]        src_b;
   logic [8:0]        sum9;
   logic [4:0]        sum_lo;
   logic [7:0]        res;
   logic              res_c;
   logic              res_dc;
   logic              wr_work;
   logic              wr_file;
   logic              upd_cdc;
   logic              upd_z;
   logic              skip_cond;
   logic              bus_file;
   logic [7:0]        rd_mux;

   // One-hot select of the bit an instruction works on
   function automatic logic [7:0] bit_mask(input logic [2:0] b);
      bit_mask = 8'h01 << b;
   endfunction

   // File read as an instruction sees it; the port shows its pins
   function automatic logic [7:0] file_read(input logic [FILE_W-1:0] f);
      if (f == FILE_W'(`BBX_PORT_ADDR)) begin
         file_read = port_pins;
      end else begin
         file_read = file_mem[f];
      end
   endfunction

   // Handshake: accepted whenever not frozen; a NOP cycle eats one
   assign ins_ready = ce;
   assign exec_fire = ce & ins_valid & (state == st_exec);
   assign nop_cycle = (state == st_nop);
   assign skip_next = exec_fire & skip_cond;
   assign port_latch = file_mem[FILE_W'(`BBX_PORT_ADDR)];
   assign bus_file = bus_addr[`BBX_FILE_WIN];

   // Operand fetch and shared adder for both add forms
   always_comb begin
      opnd = file_read(ins_file);
      if (ins_op == op_add_literal_to_work) begin
         src_b = ins_literal;
      end else begin
         src_b = opnd;
      end
      sum9 = {1'b0, work} + {1'b0, src_b};
      sum_lo = {1'b0, work[3:0]} + {1'b0, src_b[3:0]};
      res_c = sum9[8];
      res_dc = sum_lo[4];
   end

   // Operation select: result, destination and which flags move
   always_comb begin
      res = 8'h00;
      wr_work = 1'b0;
      wr_file = 1'b0;
      upd_cdc = 1'b0;
      upd_z = 1'b0;
      skip_cond = 1'b0;
      case (ins_op)
         op_add_literal_to_work: begin
            res = sum9[7:0];
            wr_work = 1'b1;
            upd_cdc = 1'b1;
            upd_z = 1'b1;
         end
         op_add_work_to_file: begin
            res = sum9[7:0];
            wr_work = ~ins_dest;
            wr_file = ins_dest;
            upd_cdc = 1'b1;
            upd_z = 1'b1;
         end
         op_and_literal_with_work: begin
            res = work & ins_literal;
            wr_work = 1'b1;
            upd_z = 1'b1;
         end
         op_and_work_with_file: begin
            res = work & opnd;
            wr_work = ~ins_dest;
            wr_file = ins_dest;
            upd_z = 1'b1;
         end
         op_file_bit_clear: begin
            res = opnd & ~bit_mask(ins_bit);
            wr_file = 1'b1;
         end
         op_file_bit_set: begin
            res = opnd | bit_mask(ins_bit);
            wr_file = 1'b1;
         end
         op_test_bit_skip_when_clear: begin
            skip_cond = ~opnd[ins_bit];
         end
         default: begin
            res = 8'h00;
         end
      endcase
   end

   // Sequencer: a taken skip turns the next cycle into a NOP
   always_ff @(posedge clock) begin
      if (!nrst) begin
         state <= st_exec;
      end else if (ce) begin
         case (state)
            st_exec: begin
               if (skip_next) begin
                  state <= st_nop;
               end
            end
            st_nop: begin
               state <= st_exec;
            end
            default: begin
               state <= st_exec;
            end
         endcase
      end
   end

   // Working register; an executing instruction beats a bus write
   always_ff @(posedge clock) begin
      if (!nrst) begin
         work <= `BBX_WORK_RST;
      end else if (ce) begin
         if (exec_fire && wr_work) begin
            work <= res;
         end else if (bus_wr && bus_addr == `BBX_REG_WORK) begin
            work <= bus_wdata;
         end
      end
   end

   // Flags; only the instruction's own flags move, bus loses the cycle
   always_ff @(posedge clock) begin
      if (!nrst) begin
         carry <= 1'b0;
         digit_carry_flag <= 1'b0;
         zero <= 1'b0;
      end else if (ce) begin
         if (exec_fire) begin
            if (upd_cdc) begin
               carry <= res_c;
               digit_carry_flag <= res_dc;
            end
            if (upd_z) begin
               zero <= (res == 8'h00);
            end
         end else if (bus_wr && bus_addr == `BBX_REG_FLAGS) begin
            carry <= bus_wdata[`BBX_FLAG_C];
            digit_carry_flag <= bus_wdata[`BBX_FLAG_DIG];
            zero <= bus_wdata[`BBX_FLAG_Z];
         end
      end
   end

   // Prescaler ownership bit, set by software
   always_ff @(posedge clock) begin
      if (!nrst) begin
         prescaler_assigned <= 1'b0;
      end else if (ce && bus_wr && bus_addr == `BBX_REG_CTRL) begin
         prescaler_assigned <= bus_wdata[`BBX_CTRL_PSA];
      end
   end

   // File space; port latch lives at its own address in the array
   always_ff @(posedge clock) begin
      if (!nrst) begin
         for (int i = 0; i < DEPTH; i++) begin
            file_mem[i] <= `BBX_FILE_RST;
         end
      end else if (ce) begin
         if (exec_fire && wr_file) begin
            file_mem[ins_file] <= res;
         end else if (bus_wr && bus_file) begin
            file_mem[bus_addr[FILE_W-1:0]] <= bus_wdata;
         end
      end
   end

   // Prescaler clear pulse, one cycle after the timer write
   always_ff @(posedge clock) begin
      if (!nrst) begin
         prescaler_clear <= 1'b0;
      end else if (ce) begin
         prescaler_clear <= exec_fire & wr_file & prescaler_assigned &
            (ins_file == FILE_W'(`BBX_TMR_ADDR));
      end
   end

   // Read decode; unmapped addresses answer zero
   always_comb begin
      if (bus_file) begin
         rd_mux = file_mem[bus_addr[FILE_W-1:0]];
      end else if (bus_addr == `BBX_REG_WORK) begin
         rd_mux = work;
      end else if (bus_addr == `BBX_REG_FLAGS) begin
         rd_mux = {5'h00, zero, digit_carry_flag, carry};
      end else if (bus_addr == `BBX_REG_CTRL) begin
         rd_mux = {7'h00, prescaler_assigned};
      end else if (bus_addr == `BBX_REG_STATE) begin
         rd_mux = {7'h00, nop_cycle};
      end else begin
         rd_mux = 8'h00;
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clock) begin
      if (!nrst) begin
         bus_rdata <= `BBX_RDATA_RST;
      end else if (ce) begin
         bus_rdata <= bus_rd ? rd_mux : 8'h00;
      end
   end

   // Checks on the execute behaviour
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   sequence skip_taken_s;
      exec_fire && ins_op == op_test_bit_skip_when_clear && !opnd[ins_bit];
   endsequence

   sequence nop_slot_s;
      nop_cycle && !exec_fire;
   endsequence

   chk_port_pin_read: assert property (
      exec_fire && ins_op == op_and_work_with_file && ins_dest &&
      ins_file == FILE_W'(`BBX_PORT_ADDR)
      |=> port_latch == ($past(work) & $past(port_pins)))
      else $error("port write-back did not use pin levels");

   chk_timer_prescale: assert property (
      exec_fire && wr_file && prescaler_assigned &&
      ins_file == FILE_W'(`BBX_TMR_ADDR) |=> prescaler_clear)
      else $error("timer write did not clear prescaler");

   chk_skip_nop_slot: assert property (
      skip_taken_s |=> nop_slot_s)
      else $error("taken skip did not give a nop cycle");

   chk_nop_one_cycle: assert property (
      nop_cycle && ce |=> !nop_cycle)
      else $error("nop cycle lasted more than one cycle");

   chk_literal_add: assert property (
      exec_fire && ins_op == op_add_literal_to_work
      |=> work == 8'($past(work) + $past(ins_literal)) &&
      carry == (9'($past(work)) + 9'($past(ins_literal)) > 9'h0FF))
      else $error("literal add gave wrong sum or carry");

   chk_file_add_flags: assert property (
      exec_fire && ins_op == op_add_work_to_file
      |=> digit_carry_flag == (5'($past(work[3:0])) +
      5'($past(opnd[3:0])) > 5'h0F) && zero == ($past(res) == 8'h00))
      else $error("file add flags wrong");

   chk_dest_work: assert property (
      exec_fire && !ins_dest && (ins_op == op_add_work_to_file ||
      ins_op == op_and_work_with_file) |=> work == $past(res))
      else $error("destination zero did not reach work");

   chk_dest_file: assert property (
      exec_fire && ins_dest && !bus_wr && (ins_op == op_add_work_to_file ||
      ins_op == op_and_work_with_file)
      |=> $stable(work) && file_mem[$past(ins_file)] == $past(res))
      else $error("destination one did not reach the file");

   chk_literal_and: assert property (
      exec_fire && ins_op == op_and_literal_with_work
      |=> work == ($past(work) & $past(ins_literal)) && $stable(carry) &&
      $stable(digit_carry_flag) && zero == (work == 8'h00))
      else $error("literal and wrong or touched carries");

   chk_file_and: assert property (
      exec_fire && ins_op == op_and_work_with_file
      |=> zero == ($past(res) == 8'h00) && $stable(carry))
      else $error("file and flags wrong");

   chk_bit_clear: assert property (
      exec_fire && ins_op == op_file_bit_clear
      |=> file_mem[$past(ins_file)] == ($past(opnd) &
      ~bit_mask($past(ins_bit))) && $stable({carry, zero}))
      else $error("bit clear wrong");

   chk_bit_set: assert property (
      exec_fire && ins_op == op_file_bit_set
      |=> file_mem[$past(ins_file)] == ($past(opnd) |
      bit_mask($past(ins_bit))) && $stable(digit_carry_flag))
      else $error("bit set wrong");

   chk_skip_quiet: assert property (
      skip_taken_s ##1 nop_slot_s ##0 !bus_wr |=> $stable({carry,
      digit_carry_flag, zero}) && $stable(work))
      else $error("skip or nop cycle changed state");

   chk_no_skip_set: assert property (
      exec_fire && ins_op == op_test_bit_skip_when_clear && opnd[ins_bit]
      |=> !nop_cycle)
      else $error("skip taken on a set bit");

   chk_zero_exact: assert property (
      exec_fire && upd_z |=> zero == ($past(res) == 8'h00))
      else $error("zero flag does not match result");

endmodule

/* File: rtl/bbx_pkg.sv */
// Types of the byte and bit execute block: operation codes and states.
// Assumes the core's decoder delivers one of these one-hot codes.
package bbx_pkg;

   // One-hot operation codes presented by the decoder
   typedef enum logic [7:0] {
      op_nop                     = 8'h01,
      op_add_literal_to_work     = 8'h02,
      op_add_work_to_file        = 8'h04,
      op_and_literal_with_work   = 8'h08,
      op_and_work_with_file      = 8'h10,
      op_file_bit_clear          = 8'h20,
      op_file_bit_set            = 8'h40,
      op_test_bit_skip_when_clear = 8'h80
   } bbx_op_t;

   // Execute or discarded second cycle
   typedef enum logic [1:0] {
      st_exec = 2'b01,
      st_nop  = 2'b10
   } bbx_state_t;

endpackage

/* File: tb/tb_bbx_exec.sv */
// Self-checking bench for the byte and bit execute block.
// Assumes bbx_cfg.svh and bbx_pkg are compiled first; ce is held high.
`timescale 1ns/1ps
module tb_bbx_exec;
   import bbx_pkg::*;
   logic       clock, nrst, ce, ins_valid, ins_ready, ins_dest;
   logic       skip_next, nop_cycle, prescaler_clear, bus_wr, bus_rd;
   logic       carry, digit_carry_flag, zero, rd_d, iv_d, d, sk_d;
   bbx_op_t    ins_op, op;
   logic [6:0] ins_file, f;
   logic [2:0] ins_bit;
   logic [7:0] ins_literal, port_pins, port_latch, work, bus_addr;
   logic [7:0] bus_wdata, bus_rdata, rs, w, v, k, r, q, ad_d;
   logic [7:0] rq[$];
   logic [2:0] pq[$];
   int         miscompares, compares;

   bbx_exec i_bbx_exec (.clock(clock), .nrst(nrst), .ce(ce),
      .ins_valid(ins_valid), .ins_ready(ins_ready), .ins_op(ins_op),
      .ins_file(ins_file), .ins_bit(ins_bit), .ins_dest(ins_dest),
      .ins_literal(ins_literal), .skip_next(skip_next),
      .nop_cycle(nop_cycle), .prescaler_clear(prescaler_clear),
      .port_pins(port_pins), .port_latch(port_latch), .work(work),
      .carry(carry), .digit_carry_flag(digit_carry_flag), .zero(zero),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata));

   // 100 ns clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // Fixed-seed 8-bit xorshift, never reaches zero
   function automatic logic [7:0] rnd();
      rs = rs ^ (rs << 7);
      rs = rs ^ (rs >> 5);
      rs = rs ^ (rs << 3);
      return rs;
   endfunction

   // Expected flag byte of an add: zero 2, digit carry 1, carry 0
   function automatic logic [7:0] fadd(input logic [7:0] a, b);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, b};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      return {5'h00, s[7:0] == 8'h00, h[4], s[8]};
   endfunction

   task cmp(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One cycle of stimulus; every instruction and bus input set once per edge
   task step(input logic iv, input bbx_op_t o, input logic [6:0] fa,
             input logic [2:0] b, input logic dd, input logic [7:0] kk,
             input logic wr, input logic rd, input logic [7:0] a, wd);
      @(posedge clock);
      ins_valid <= iv;
      ins_op <= o;
      ins_file <= fa;
      ins_bit <= b;
      ins_dest <= dd;
      ins_literal <= kk;
      bus_wr <= wr;
      bus_rd <= rd;
      bus_addr <= a;
      bus_wdata <= wd;
   endtask

   // Instruction with expected {prescaler_clear, nop_cycle} after it;
   // a taken skip is exactly the one followed by a nop cycle
   task ex(input bbx_op_t o, input logic [6:0] fa, input logic [2:0] b,
           input logic dd, input logic [7:0] kk, input logic [1:0] e);
      pq.push_back({e[0], e});
      step(1'b1, o, fa, b, dd, kk, 1'b0, 1'b0, 8'h00, 8'h00);
   endtask

   task wr(input logic [7:0] a, input logic [7:0] wd);
      step(1'b0, op_nop, 7'h00, 3'h0, 1'b0, 8'h00, 1'b1, 1'b0, a, wd);
   endtask

   task rd(input logic [7:0] a, input logic [7:0] e);
      rq.push_back(e);
      step(1'b0, op_nop, 7'h00, 3'h0, 1'b0, 8'h00, 1'b0, 1'b1, a, 8'h00);
   endtask

   task tally_and_finish;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Remember which strobes the design took at this edge
   always @(posedge clock) begin
      rd_d <= bus_rd;
      iv_d <= ins_valid;
      sk_d <= skip_next;
      ad_d <= bus_addr;
   end

   // Results settle mid-cycle; compare against the oldest note
   always @(negedge clock) begin
      if (rd_d && rq.size() > 0) begin
         q = rq.pop_front();
         cmp(bus_rdata, q);
         // Direct outputs must agree with what the bus just returned
         if (ad_d == 8'h00) cmp(work, q);
         if (ad_d == 8'h01) cmp({5'h00, zero, digit_carry_flag, carry}, q);
         if (ad_d == 8'h85) cmp(port_latch, q);
      end
      if (iv_d && pq.size() > 0)
         cmp({4'h0, ins_ready, sk_d, prescaler_clear, nop_cycle},
             {4'h0, ce, pq.pop_front()});
   end

   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      ins_valid = 1'b0;
      ins_op = op_nop;
      ins_file = 7'h00;
      ins_bit = 3'h0;
      ins_dest = 1'b0;
      ins_literal = 8'h00;
      port_pins = 8'h00;
      bus_addr = 8'h00;
      bus_wdata = 8'h00;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      rs = 8'h26;
      miscompares = 0;
      compares = 0;
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      // Reset values, unmapped write ignored and read as zero
      rd(8'h00, 8'h00);
      rd(8'h01, 8'h00);
      rd(8'h02, 8'h00);
      rd(8'h03, 8'h00);
      rd(8'h85, 8'h00);
      wr(8'h10, 8'hFF);
      rd(8'h10, 8'h00);
      $display("test reset done");
      // Literal add and AND, corner values first
      for (int i = 0; i < 6; i++) begin
         w = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : rnd();
         k = (i == 0) ? 8'h01 : (i == 1) ? 8'h00 : rnd();
         wr(8'h00, w);
         ex(op_add_literal_to_work, 7'h00, 3'h0, 1'b0, k, 2'b00);
         rd(8'h00, w + k);
         rd(8'h01, fadd(w, k));
         wr(8'h00, w);
         wr(8'h01, 8'h03);
         ex(op_and_literal_with_work, 7'h00, 3'h0, 1'b0, k, 2'b00);
         rd(8'h00, w & k);
         rd(8'h01, {5'h00, (w & k) == 8'h00, 2'b11});
      end
      $display("test literal ops done");
      // File add and AND, both destinations, top address included
      for (int i = 0; i < 4; i++) begin
         v = rnd();
         f = (i == 0) ? 7'h7F : {1'b1, v[5:0]};
         w = rnd();
         v = rnd();
         op = i[0] ? op_and_work_with_file : op_add_work_to_file;
         d = i[1];
         r = i[0] ? (w & v) : (w + v);
         wr(8'h00, w);
         wr({1'b1, f}, v);
         wr(8'h01, 8'h03);
         ex(op, f, 3'h0, d, 8'h00, 2'b00);
         rd(8'h00, d ? w : r);
         rd({1'b1, f}, d ? r : v);
         rd(8'h01, i[0] ? {5'h00, r == 8'h00, 2'b11}
            : fadd(w, v));
      end
      $display("test file ops done");
      // Bit clear then set on every bit position, flags held
      for (int b = 0; b < 8; b++) begin
         v = rnd();
         f = {1'b1, v[5:0]};
         v = rnd();
         wr({1'b1, f}, v);
         wr(8'h01, 8'h07);
         ex(op_file_bit_clear, f, b[2:0], 1'b0, 8'h00, 2'b00);
         rd({1'b1, f}, v & ~(8'h01 << b));
         ex(op_file_bit_set, f, b[2:0], 1'b0, 8'h00, 2'b00);
         rd({1'b1, f}, v | (8'h01 << b));
         rd(8'h01, 8'h07);
      end
      $display("test bit ops done");
      // Test-skip: set bit runs the next add, clear bit drops it
      for (int i = 0; i < 2; i++) begin
         v = rnd();
         f = {1'b1, v[5:0]};
         v = rnd();
         wr({1'b1, f}, i ? (v & 8'hF7) : (v | 8'h08));
         wr(8'h00, 8'h10);
         wr(8'h01, 8'h05);
         ex(op_test_bit_skip_when_clear, f, 3'h3, 1'b0, 8'h00,
            {1'b0, i == 1});
         ex(op_add_literal_to_work, 7'h00, 3'h0, 1'b0, 8'h01,
            2'b00);
         rd(8'h00, i ? 8'h10 : 8'h11);
         rd(8'h01, i ? 8'h05 : 8'h00);
      end
      $display("test skip done");
      // Timer counter writes clear the prescaler only when assigned
      wr(8'h02, 8'h01);
      ex(op_file_bit_set, 7'h01, 3'h0, 1'b0, 8'h00, 2'b10);
      ex(op_add_work_to_file, 7'h01, 3'h0, 1'b0, 8'h00, 2'b00);
      ex(op_and_work_with_file, 7'h01, 3'h0, 1'b1, 8'h00, 2'b10);
      wr(8'h02, 8'h00);
      ex(op_file_bit_set, 7'h01, 3'h0, 1'b0, 8'h00, 2'b00);
      $display("test timer done");
      // Port read-modify-write takes pin levels, not the latch
      wr(8'h85, 8'hFF);
      port_pins <= 8'h0F;
      ex(op_file_bit_set, 7'h05, 3'h7, 1'b0, 8'h00, 2'b00);
      rd(8'h85, 8'h8F);
      wr(8'h85, 8'hFF);
      ex(op_test_bit_skip_when_clear, 7'h05, 3'h4, 1'b0, 8'h00,
         2'b01);
      ex(op_nop, 7'h00, 3'h0, 1'b0, 8'h00, 2'b00);
      v = rnd();
      wr(8'h00, 8'hFF);
      port_pins <= v;
      ex(op_and_work_with_file, 7'h05, 3'h0, 1'b1, 8'h00, 2'b00);
      rd(8'h85, v);
      step(1'b0, op_nop, 7'h00, 3'h0, 1'b0, 8'h00, 1'b0, 1'b0, 8'h00, 8'h00);
      $display("test port done");
      for (int n = 0; n < 10 && (rq.size() > 0 || pq.size() > 0); n++)
         @(posedge clock);
      if (rq.size() > 0 || pq.size() > 0) miscompares++;
      tally_and_finish();
   end
endmodule
